// File: core/ccc_pkg.sv
// package: register map, field positions and bus carrier for ccc
// Operation
// - direction bit 1 makes a channel output compare, 0 input capture
// - overflow toggle bit toggles compare pin on counter wrap; inert in capture
// - channel 7 override beats overflow toggle, which beats forced compare
// - compare action code: 00 off, 01 toggle, 10 low, 11 high
// - nonzero action code makes an output compare pin an output of compare logic
// - action code reaches the pin only while its channel 7 mask bit is clear
// - edge code: 00 off, 01 rising, 10 falling, 11 both edges
// - low edge codes also steer narrow accumulators; channel 0 code steers B
// - eight channel enables gate the eight channel flags onto interrupts
// - overflow interrupt requested only when flag and its enable are set
// - counter reset enable lets channel 7 compare clear the counter
// - with reset enabled, value 0 holds counter at 0; all ones sets no overflow flag
// - three bit prescale code gives divide factors 1 to 128
// - new prescale code adopted only when all prescale stages are zero
// - flag registers clear on written ones, zeros ignored, read anytime
// - fast clear: capture value read or compare value write clears flag
// - fast clear: any counter access clears the overflow flag
// - channel 0 flag also set by accumulator B, flags 3..0 by narrow ones
// - overflow flag set on wrap from all ones; written bit 7 clears it
// - values reset to zero, capture counter, ignore writes in capture mode
// - accumulator A enable cascades narrow 3 and 2 and enables edge flag
// - accumulator A works without timer enable and shares channel 7 input
`default_nettype none
package ccc_pkg;
  localparam logic [7:0] ADDR_DIR      = 8'h40;
  localparam logic [7:0] ADDR_FORCE    = 8'h41;
  localparam logic [7:0] ADDR_MASK7    = 8'h42;
  localparam logic [7:0] ADDR_DATA7    = 8'h43;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h44;
  localparam logic [7:0] ADDR_CNT_LO   = 8'h45;
  localparam logic [7:0] ADDR_SYS1     = 8'h46;
  localparam logic [7:0] ADDR_TOV      = 8'h47;
  localparam logic [7:0] ADDR_OUT_HI   = 8'h48;
  localparam logic [7:0] ADDR_OUT_LO   = 8'h49;
  localparam logic [7:0] ADDR_EDGE_HI  = 8'h4A;
  localparam logic [7:0] ADDR_EDGE_LO  = 8'h4B;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h4C;
  localparam logic [7:0] ADDR_SYS2     = 8'h4D;
  localparam logic [7:0] ADDR_CFLAG    = 8'h4E;
  localparam logic [7:0] ADDR_OFLAG    = 8'h4F;
  localparam logic [7:0] ADDR_VAL_BASE = 8'h50;
  localparam logic [7:0] ADDR_VAL_LAST = 8'h5F;
  localparam logic [7:0] ADDR_ACCA     = 8'h60;
  // field positions
  localparam int SYS1_TEN_BIT = 7;
  localparam int SYS1_FFC_BIT = 4;
  localparam int SYS2_OVI_BIT = 7;
  localparam int SYS2_CRE_BIT = 3;
  localparam int OFLAG_OVF_BIT = 7;
  localparam int ACCA_EN_BIT = 6;
  localparam logic [7:0] ACCA_RD_MASK = 8'h7F;
  // reset values and counts
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_VAL  = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [6:0]  PRE_ZERO = 7'h00;
  // compare action codes {mode, level}
  localparam logic [1:0] ACT_OFF  = 2'h0;
  localparam logic [1:0] ACT_TOG  = 2'h1;
  localparam logic [1:0] ACT_LOW  = 2'h2;
  localparam logic [1:0] ACT_HIGH = 2'h3;
  // register bus request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccc_bus_s;
endpackage : ccc_pkg
`default_nettype wire

// File: core/ccc_prescale.sv
// prescaler: divide-by-two stages feeding the main counter tick
`default_nettype none
module ccc_prescale (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [6:0] stage_r;
  logic [2:0] sel_act_r;
  logic [6:0] mask;

  // stages count while the timer runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage_r <= ccc_pkg::PRE_ZERO;
    end else if (run) begin
      stage_r <= stage_r + 7'h01;
    end
  end

  // adopting only at all-zero avoids a short first period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_act_r <= 3'h0;
    end else if (stage_r == ccc_pkg::PRE_ZERO) begin
      sel_act_r <= sel;
    end
  end

  // tick once per 2**sel cycles: low sel stages all ones
  assign mask = 7'((8'h01 << sel_act_r) - 8'h01);
  assign tick = run && ((stage_r & mask) == mask);

  property p_sel_hold;
    @(posedge core_clk) disable iff (rst)
    (sel_act_r != $past(sel_act_r)) |-> ($past(stage_r) == 7'h00);
  endproperty
  a_sel_hold: assert property (p_sel_hold)
    else $error("prescale code adopted while stages nonzero");
endmodule : ccc_prescale
`default_nettype wire

// File: core/ccc_top.sv
// timer channel control: compare/capture, flags, counter, accumulator A
`default_nettype none
module ccc_top (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire ccc_pkg::ccc_bus_s bus,
  output logic [7:0]            rdata,
  input  wire logic [7:0]       tpin_in,
  output logic [7:0]            tpin_out,
  output logic [7:0]            tpin_oe_n,
  input  wire logic [3:0]       narrow_accum_set,
  input  wire logic             wide_b_set,
  output logic [7:0]            narrow_edge_sel,
  output logic [1:0]            wide_b_edge_sel,
  output logic                  accum_a_enable,
  output logic                  accum_edge_flag_en,
  output logic                  accum_a_pin,
  output logic [7:0]            chan_irq,
  output logic                  ovf_irq
);
  logic [7:0]  dir_r, mask7_r, data7_r, sys1_r, tov_r, ie_r, sys2_r;
  logic [15:0] out_ctl_r, edge_r;
  logic [7:0]  cflag_r, acca_r, pin_r, oe_n_r, prev_r, rdata_r;
  logic [7:0]  chan_irq_r;
  logic        ovf_r, ovf_irq_r;
  logic [15:0] cnt_r;
  logic [15:0] val_r [8];
  logic        tick, reset7, ovf_evt, ovf_clr, ffc;
  logic [7:0]  match, cap, force_w, flag_set, flag_clr, pin_nxt, acc_val;
  logic [7:0]  rdata_nxt, acc_set;
  logic [2:0]  bch;

  // true when the address falls in the channel value window
  function automatic logic is_val(input logic [7:0] a);
    return (a >= ccc_pkg::ADDR_VAL_BASE) && (a <= ccc_pkg::ADDR_VAL_LAST);
  endfunction : is_val

  // pin value after a compare action code
  function automatic logic act_pin(input logic [1:0] c, input logic p);
    case (c)
      ccc_pkg::ACT_TOG:  return ~p;
      ccc_pkg::ACT_LOW:  return 1'b0;
      ccc_pkg::ACT_HIGH: return 1'b1;
      default:           return p;
    endcase
  endfunction : act_pin

  assign bch = bus.addr[3:1];
  assign ffc = sys1_r[ccc_pkg::SYS1_FFC_BIT];
  // accumulator B reaches channel 0, the narrow ones channels 3..0
  assign acc_set = {4'h0, narrow_accum_set} | {7'h00, wide_b_set};

  ccc_prescale u_pre (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (sys1_r[ccc_pkg::SYS1_TEN_BIT]),
    .sel      (sys2_r[2:0]),
    .tick     (tick)
  );

  // channel 7 compare restarts the counter in modulus mode
  assign reset7 = match[7] && sys2_r[ccc_pkg::SYS2_CRE_BIT];
  // a modulus restart from all ones is no wrap
  assign ovf_evt = tick && (cnt_r == ccc_pkg::CNT_MAX) && !reset7;

  // main counter; software writes are ignored in normal operation
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= ccc_pkg::RST_VAL;
    end else if (reset7) begin
      cnt_r <= ccc_pkg::RST_VAL;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // per-channel compare, capture and pin logic
  for (genvar n = 0; n < 8; n++) begin : g_ch
    logic [1:0] code;
    logic [1:0] edg;
    logic       rise, fall;
    assign code = out_ctl_r[2*n+1:2*n];
    assign edg  = edge_r[2*n+1:2*n];
    assign rise = tpin_in[n] && !prev_r[n];
    assign fall = !tpin_in[n] && prev_r[n];
    assign match[n] = tick && dir_r[n] && (cnt_r == val_r[n]);
    assign cap[n] = !dir_r[n] && ((edg[0] && rise) || (edg[1] && fall));
    assign force_w[n] = bus.wr && (bus.addr == ccc_pkg::ADDR_FORCE)
                        && bus.wdata[n];
    assign acc_val[n] = ffc && is_val(bus.addr) && (bch == n)
                        && ((bus.rd && !dir_r[n]) || (bus.wr && dir_r[n]));

    // override, then overflow toggle, then force, then own compare
    always_comb begin
      pin_nxt[n] = pin_r[n];
      if (match[7] && mask7_r[n] && dir_r[n]) begin
        pin_nxt[n] = data7_r[n];
      end else if (tov_r[n] && dir_r[n] && ovf_evt) begin
        pin_nxt[n] = ~pin_r[n];
      end else if (force_w[n] && dir_r[n] && !mask7_r[n]) begin
        pin_nxt[n] = act_pin(code, pin_r[n]);
      end else if (match[n] && !mask7_r[n]) begin
        pin_nxt[n] = act_pin(code, pin_r[n]);
      end
    end

    // forced action sets no flag; accumulators may also set low flags
    assign flag_set[n] = (match[n] && !force_w[n]) || cap[n]
                         || acc_set[n];

    // value register: capture latch or compare target
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        val_r[n] <= ccc_pkg::RST_VAL;
      end else if (cap[n]) begin
        val_r[n] <= cnt_r;
      end else if (bus.wr && is_val(bus.addr) && bch == n && dir_r[n]) begin
        if (bus.addr[0]) begin
          val_r[n][7:0] <= bus.wdata;
        end else begin
          val_r[n][15:8] <= bus.wdata;
        end
      end
    end
  end

  // pin drivers; oe_n low while compare logic owns the pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_r  <= ccc_pkg::RST_BYTE;
      oe_n_r <= 8'hFF;
      prev_r <= ccc_pkg::RST_BYTE;
    end else begin
      pin_r  <= pin_nxt;
      prev_r <= tpin_in;
      for (int i = 0; i < 8; i++) begin
        oe_n_r[i] <= !(dir_r[i] && (out_ctl_r[2*i+1 +: 1] != 1'b0
                    || out_ctl_r[2*i] || mask7_r[i]));
      end
    end
  end

  // software-written control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dir_r <= ccc_pkg::RST_BYTE;
      mask7_r <= ccc_pkg::RST_BYTE;
      data7_r <= ccc_pkg::RST_BYTE;
      sys1_r <= ccc_pkg::RST_BYTE;
      tov_r <= ccc_pkg::RST_BYTE;
      out_ctl_r <= ccc_pkg::RST_VAL;
      edge_r <= ccc_pkg::RST_VAL;
      ie_r <= ccc_pkg::RST_BYTE;
      sys2_r <= ccc_pkg::RST_BYTE;
      acca_r <= ccc_pkg::RST_BYTE;
    end else if (bus.wr) begin
      if (bus.addr == ccc_pkg::ADDR_DIR) begin
        dir_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_MASK7) begin
        mask7_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_DATA7) begin
        data7_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_SYS1) begin
        sys1_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_TOV) begin
        tov_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_OUT_HI) begin
        out_ctl_r[15:8] <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_OUT_LO) begin
        out_ctl_r[7:0] <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_EDGE_HI) begin
        edge_r[15:8] <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_EDGE_LO) begin
        edge_r[7:0] <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_IRQ_EN) begin
        ie_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_SYS2) begin
        sys2_r <= bus.wdata;
      end else if (bus.addr == ccc_pkg::ADDR_ACCA) begin
        acca_r <= bus.wdata & ccc_pkg::ACCA_RD_MASK;
      end
    end
  end

  // channel flags: written ones clear, hardware set wins over clear
  assign flag_clr = ((bus.wr && bus.addr == ccc_pkg::ADDR_CFLAG)
                    ? bus.wdata : 8'h00) | acc_val;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cflag_r <= ccc_pkg::RST_BYTE;
    end else begin
      cflag_r <= (cflag_r & ~flag_clr) | flag_set;
    end
  end

  // overflow flag: cleared by bit 7 write or, with fast clear, any counter access
  assign ovf_clr = (bus.wr && bus.addr == ccc_pkg::ADDR_OFLAG
                   && bus.wdata[ccc_pkg::OFLAG_OVF_BIT])
                   || (ffc && (bus.wr || bus.rd)
                   && (bus.addr == ccc_pkg::ADDR_CNT_HI
                   || bus.addr == ccc_pkg::ADDR_CNT_LO));
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
    end else if (ovf_clr) begin
      ovf_r <= 1'b0;
    end
  end

  // interrupt requests, one cycle behind the flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_irq_r <= ccc_pkg::RST_BYTE;
      ovf_irq_r  <= 1'b0;
    end else begin
      chan_irq_r <= cflag_r & ie_r;
      ovf_irq_r  <= ovf_r && sys2_r[ccc_pkg::SYS2_OVI_BIT];
    end
  end

  // read mux; counter bytes are read live, not latched as a word
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus.addr == ccc_pkg::ADDR_DIR) begin
      rdata_nxt = dir_r;
    end else if (bus.addr == ccc_pkg::ADDR_MASK7) begin
      rdata_nxt = mask7_r;
    end else if (bus.addr == ccc_pkg::ADDR_DATA7) begin
      rdata_nxt = data7_r;
    end else if (bus.addr == ccc_pkg::ADDR_CNT_HI) begin
      rdata_nxt = cnt_r[15:8];
    end else if (bus.addr == ccc_pkg::ADDR_CNT_LO) begin
      rdata_nxt = cnt_r[7:0];
    end else if (bus.addr == ccc_pkg::ADDR_SYS1) begin
      rdata_nxt = sys1_r;
    end else if (bus.addr == ccc_pkg::ADDR_TOV) begin
      rdata_nxt = tov_r;
    end else if (bus.addr == ccc_pkg::ADDR_OUT_HI) begin
      rdata_nxt = out_ctl_r[15:8];
    end else if (bus.addr == ccc_pkg::ADDR_OUT_LO) begin
      rdata_nxt = out_ctl_r[7:0];
    end else if (bus.addr == ccc_pkg::ADDR_EDGE_HI) begin
      rdata_nxt = edge_r[15:8];
    end else if (bus.addr == ccc_pkg::ADDR_EDGE_LO) begin
      rdata_nxt = edge_r[7:0];
    end else if (bus.addr == ccc_pkg::ADDR_IRQ_EN) begin
      rdata_nxt = ie_r;
    end else if (bus.addr == ccc_pkg::ADDR_SYS2) begin
      rdata_nxt = sys2_r;
    end else if (bus.addr == ccc_pkg::ADDR_CFLAG) begin
      rdata_nxt = cflag_r;
    end else if (bus.addr == ccc_pkg::ADDR_OFLAG) begin
      rdata_nxt = {ovf_r, 7'h00};
    end else if (is_val(bus.addr)) begin
      rdata_nxt = bus.addr[0] ? val_r[bch][7:0] : val_r[bch][15:8];
    end else if (bus.addr == ccc_pkg::ADDR_ACCA) begin
      rdata_nxt = acca_r & ccc_pkg::ACCA_RD_MASK;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= ccc_pkg::RST_BYTE;
    end else begin
      rdata_r <= bus.rd ? rdata_nxt : 8'h00;
    end
  end

  assign rdata     = rdata_r;
  assign tpin_out  = pin_r;
  assign tpin_oe_n = oe_n_r;
  assign chan_irq  = chan_irq_r;
  assign ovf_irq   = ovf_irq_r;
  // narrow accumulators and wide B take their edges from low codes
  assign narrow_edge_sel = edge_r[7:0];
  assign wide_b_edge_sel = edge_r[1:0];
  // enable ignores timer enable; cascade and edge flag follow it
  assign accum_a_enable     = acca_r[ccc_pkg::ACCA_EN_BIT];
  assign accum_edge_flag_en = acca_r[ccc_pkg::ACCA_EN_BIT];
  // accumulator A listens on the channel 7 capture pin
  assign accum_a_pin = prev_r[7];

  property p_ovf_set;
    @(posedge core_clk) disable iff (rst)
    (tick && cnt_r == 16'hFFFF && !reset7) |=> ovf_r ##1 1'b1;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set on wrap");

  property p_ovf_irq;
    @(posedge core_clk) disable iff (rst)
    (ovf_r && sys2_r[7]) |=> ovf_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq)
    else $error("overflow interrupt missing");

  property p_chan_irq;
    @(posedge core_clk) disable iff (rst)
    !ie_r[0] |=> !chan_irq[0];
  endproperty
  a_chan_irq: assert property (p_chan_irq)
    else $error("disabled channel raised interrupt");

  property p_hold_zero;
    @(posedge core_clk) disable iff (rst)
    (sys2_r[3] && dir_r[7] && val_r[7] == 16'h0000 && cnt_r == 16'h0000
     && !bus.wr)[*2] |-> cnt_r == 16'h0000 && !ovf_evt;
  endproperty
  a_hold_zero: assert property (p_hold_zero)
    else $error("counter left zero with zero modulus");

  property p_cap_nowrite;
    @(posedge core_clk) disable iff (rst)
    (!dir_r[0] && !cap[0] && bus.wr && bus.addr == 8'h50)
      |=> val_r[0] == $past(val_r[0]);
  endproperty
  a_cap_nowrite: assert property (p_cap_nowrite)
    else $error("capture value accepted a write");

  property p_w1c;
    @(posedge core_clk) disable iff (rst)
    (bus.wr && bus.addr == 8'h4E && bus.wdata[2] && !flag_set[2])
      |=> !cflag_r[2];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by written one");

  property p_oe;
    @(posedge core_clk) disable iff (rst)
    (dir_r[1] && out_ctl_r[3:2] != 2'h0) |=> !tpin_oe_n[1];
  endproperty
  a_oe: assert property (p_oe)
    else $error("compare pin not driven");

  property p_clr_low;
    @(posedge core_clk) disable iff (rst)
    (match[1] && !mask7_r[1] && out_ctl_r[3:2] == 2'h2 && !force_w[1]
     && !(tov_r[1] && ovf_evt)) |=> !tpin_out[1];
  endproperty
  a_clr_low: assert property (p_clr_low)
    else $error("clear action did not drive low");

  property p_fast_cnt;
    @(posedge core_clk) disable iff (rst)
    (ffc && bus.rd && bus.addr == 8'h44 && !ovf_evt) |=> !ovf_r;
  endproperty
  a_fast_cnt: assert property (p_fast_cnt)
    else $error("counter read did not clear overflow flag");
endmodule : ccc_top
`default_nettype wire

// File: verif/ccc_pin_model.sv
// pin model: external pin drivers and resolved timer pin levels
`default_nettype none
module ccc_pin_model (
  input  wire logic [7:0] tpin_out,
  input  wire logic [7:0] tpin_oe_n,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] tpin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin shows the design level, a released one the outside source;
  // no keeper, so a released pin never holds the design's last value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      tpin_in[i] = tpin_oe_n[i] ? ext_level[i] : tpin_out[i];
    end
  end
endmodule : ccc_pin_model
`default_nettype wire

// File: verif/ccc_top_bench.sv
// bench: register, pin, flag and accumulator checks for ccc_top
`default_nettype none
module ccc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk;
  logic              rst;
  ccc_pkg::ccc_bus_s bus;
  logic [7:0]        rdata;
  logic [7:0]        tpin_in;
  logic [7:0]        tpin_out;
  logic [7:0]        tpin_oe_n;
  logic [7:0]        ext_level;
  logic [3:0]        narrow_accum_set;
  logic              wide_b_set;
  logic [7:0]        narrow_edge_sel;
  logic [1:0]        wide_b_edge_sel;
  logic              accum_a_enable;
  logic              accum_edge_flag_en;
  logic              accum_a_pin;
  logic [7:0]        chan_irq;
  logic              ovf_irq;
  logic [7:0]        exp_q[$];
  logic [7:0]        msk_q[$];
  logic              rd_d = 1'b0;
  int                err_total;
  int                tests_run;
  localparam logic [7:0] ZADDR [17] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h48,
    8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h57, 8'h5F,
    8'h60, 8'h70};
  localparam logic [7:0] RWADDR [4] = '{8'h42, 8'h4A, 8'h4C, 8'h60};
  localparam logic [7:0] RWMASK [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h7F};
  // ch1 steps: action code, ch7 mask, expected {oe_n, out} and its mask
  localparam logic [1:0] CODE [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  localparam logic [7:0] MASK7 [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
  localparam logic [1:0] PEXP [5] = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic [1:0] PMSK [5] = '{2'h3, 2'h3, 2'h3, 2'h2, 2'h3};

  ccc_top dut_u (
    .core_clk           (core_clk),
    .rst                (rst),
    .bus                (bus),
    .rdata              (rdata),
    .tpin_in            (tpin_in),
    .tpin_out           (tpin_out),
    .tpin_oe_n          (tpin_oe_n),
    .narrow_accum_set   (narrow_accum_set),
    .wide_b_set         (wide_b_set),
    .narrow_edge_sel    (narrow_edge_sel),
    .wide_b_edge_sel    (wide_b_edge_sel),
    .accum_a_enable     (accum_a_enable),
    .accum_edge_flag_en (accum_edge_flag_en),
    .accum_a_pin        (accum_a_pin),
    .chan_irq           (chan_irq),
    .ovf_irq            (ovf_irq)
  );
  ccc_pin_model pins_u (
    .tpin_out  (tpin_out),
    .tpin_oe_n (tpin_oe_n),
    .ext_level (ext_level),
    .tpin_in   (tpin_in)
  );

  // 200 MHz clock
  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // the answer stands only in the cycle after the strobe, so sample there
  always @(posedge core_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      check(rdata & msk_q[0], exp_q[0] & msk_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_d <= bus.rd;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
  endtask : rd

  // bounded wait for pin 1, longer than two modulus periods of 65 ticks
  task automatic wait_pin(input logic [1:0] e, input logic [1:0] m);
    for (int i = 0; i < 140; i++) begin
      if (({tpin_oe_n[1], tpin_out[1]} & m) === (e & m)) break;
      @(posedge core_clk);
    end
    check({6'h00, {tpin_oe_n[1], tpin_out[1]} & m}, {6'h00, e & m});
  endtask : wait_pin

  // watchdog: the free-running overflow wait dominates, about 66k cycles
  initial begin
    repeat (95000) @(posedge core_clk);
    err_total++;
    give_verdict();
  end

  // main sequence
  initial begin
    logic [7:0] r;
    logic [1:0] code;
    bus = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    rst = 1'b1;
    ext_level = 8'hFF;
    narrow_accum_set = 4'h0;
    wide_b_set = 1'b0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(23500));
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    wr(8'h57, 8'hAB);
    wr(8'h50, 8'hCD);
    foreach (ZADDR[i]) rd(ZADDR[i], 8'h00, 8'hFF);
    foreach (RWADDR[i]) begin
      r = 8'($urandom);
      wr(RWADDR[i], r);
      rd(RWADDR[i], r & RWMASK[i], 8'hFF);
      wr(RWADDR[i], 8'h00);
    end
    // ch1 and ch7 compare; ch7 code 00 and mask clear leave pin 7 free
    wr(8'h40, 8'h82);
    wr(8'h53, 8'h10);
    wr(8'h4D, 8'h08);
    wr(8'h46, 8'h80);
    // channel 7 value still zero: modulus restart pins the counter at zero
    repeat (4) @(posedge core_clk);
    rd(8'h45, 8'h00, 8'hFF);
    wr(8'h5F, 8'h40);
    for (int s = 0; s < 5; s++) begin
      wr(8'h42, MASK7[s]);
      wr(8'h49, {4'h0, CODE[s], 2'h0});
      wait_pin(PEXP[s], PMSK[s]);
    end
    repeat (300) @(posedge core_clk);
    rd(8'h44, 8'h00, 8'hFF);
    wr(8'h46, 8'h00);
    rd(8'h4E, 8'h82, 8'h82);
    wr(8'h4C, 8'h02);
    repeat (3) @(posedge core_clk);
    check(chan_irq, 8'h02);
    wr(8'h4E, 8'h00);
    rd(8'h4E, 8'h82, 8'h82);
    wr(8'h4E, 8'hFF);
    rd(8'h4E, 8'h00, 8'hFF);
    repeat (3) @(posedge core_clk);
    check(chan_irq, 8'h00);
    // free run with no modulus restart; pin 1 toggles once at the wrap
    wr(8'h47, 8'h02);
    wr(8'h4D, 8'h80);
    wr(8'h46, 8'h80);
    for (int i = 0; i < 70000 && ovf_irq !== 1'b1; i++) @(posedge core_clk);
    check({7'h00, ovf_irq}, 8'h01);
    wr(8'h46, 8'h00);
    check({7'h00, tpin_out[1]}, 8'h01);
    rd(8'h4F, 8'h80, 8'hFF);
    wr(8'h4F, 8'h00);
    rd(8'h4F, 8'h80, 8'hFF);
    wr(8'h4F, 8'h80);
    rd(8'h4F, 8'h00, 8'hFF);
    repeat (3) @(posedge core_clk);
    check({7'h00, ovf_irq}, 8'h00);
    // capture on ch3 for every edge code, falling then rising; counter / 8
    wr(8'h4D, 8'h83);
    wr(8'h46, 8'h80);
    for (int c = 0; c < 4; c++) begin
      code = 2'(c);
      wr(8'h4B, {code, 4'h0, code});
      @(posedge core_clk);
      check(narrow_edge_sel, {code, 4'h0, code});
      check({6'h00, wide_b_edge_sel}, {6'h00, code});
      wr(8'h4E, 8'h08);
      ext_level[3] <= 1'b0;
      repeat (4) @(posedge core_clk);
      rd(8'h4E, {4'h0, code[1], 3'h0}, 8'h08);
      wr(8'h4E, 8'h08);
      ext_level[3] <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(8'h4E, {4'h0, code[0], 3'h0}, 8'h08);
    end
    // accumulator flag sources with the timer stopped
    wr(8'h46, 8'h00);
    wr(8'h4E, 8'hFF);
    r = {4'h0, 4'($urandom)};
    @(posedge core_clk);
    narrow_accum_set <= r[3:0];
    wide_b_set <= 1'b1;
    @(posedge core_clk);
    narrow_accum_set <= 4'h0;
    wide_b_set <= 1'b0;
    rd(8'h4E, r | 8'h01, 8'h0F);
    wr(8'h60, 8'h40);
    @(posedge core_clk);
    check({6'h00, accum_a_enable, accum_edge_flag_en}, 8'h03);
    ext_level[7] <= 1'b0;
    repeat (3) @(posedge core_clk);
    check({7'h00, accum_a_pin}, 8'h00);
    ext_level[7] <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({7'h00, accum_a_pin}, 8'h01);
    wr(8'h60, 8'h00);
    @(posedge core_clk);
    check({6'h00, accum_a_enable, accum_edge_flag_en}, 8'h00);
    // forced actions with the timer stopped: pin follows, no flag set
    wr(8'h42, 8'h00);
    wr(8'h4E, 8'hFF);
    for (int f = 0; f < 2; f++) begin
      wr(8'h49, {4'h0, 2'(3 - f), 2'h0});
      wr(8'h41, 8'h02);
      @(posedge core_clk);
      check({7'h00, tpin_out[1]}, 8'(1 - f));
    end
    rd(8'h4E, 8'h00, 8'h02);
    // fast clear: compare value write and capture value read drop flags
    wr(8'h46, 8'h10);
    @(posedge core_clk);
    narrow_accum_set <= 4'hA;
    @(posedge core_clk);
    narrow_accum_set <= 4'h0;
    wr(8'h53, 8'h10);
    rd(8'h56, 8'h00, 8'hFF);
    rd(8'h44, 8'h00, 8'hFF);
    rd(8'h4E, 8'h00, 8'h0A);
    repeat (3) @(posedge core_clk);
    give_verdict();
  end
endmodule : ccc_top_bench
`default_nettype wire
